// *** rgp_phy.sv ***
// PHY end of a reduced-pin double-data-rate Ethernet link.
// Assumes TXC, TD and TX_CTL come from the MAC asynchronously and the user side is on clock.
//
// Function
// - PHY drives continuous receive clock
// - Low nibble rising edge, high falling
// - RX_CTL carries data valid on rise
// - RX_CTL falling bit is error xor valid
// - Controls taken at rise, xor at fall
// - Good frame high-high, idle low-low
// - Errored frame high then low
// - Low-high with 0F/1F is extend
// - High-low error propagation, high-high data
// - Period 8, 40 or 400 ns; gigabit RXC here runs at 20 ns, two 10 ns core cycles
// - Stretch at most three slow periods
// - All link signals are active high
// - Carrier sense FF, false carrier 0E
// - Slow speeds behave like gigabit
`default_nettype none

module rgp_phy
  import rgp_pkg::*;
(
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link pins from the MAC
  input wire rgp_pins_t tx_pins,
  // Link pins to the MAC
  output var rgp_pins_t rx_pins,
  // Bytes received from the MAC
  output logic tx_valid,
  output var rgp_gmii_t tx_byte,
  output var rgp_tx_kind_t tx_kind,
  // Bytes to send to the MAC
  input wire logic rx_valid,
  input wire rgp_rx_kind_t rx_kind,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Speed and in-band status
  input wire logic [1:0] speed,
  input wire logic link_up,
  input wire logic full_duplex
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic rgp_tx_kind_t tx_decode(input rgp_gmii_t b);
    rgp_tx_kind_t k;
    k = TX_RSVD;
    if (!b.en && !b.er) begin
      k = TX_IDLE;
    end else if (b.en && !b.er) begin
      k = TX_DATA;
    end else if (b.en && b.er) begin
      k = TX_ERR;
    end else if (b.data == RGP_CODE_EXT) begin
      k = TX_EXT;
    end else if (b.data == RGP_CODE_EXT_ERR) begin
      k = TX_EXT_ERR;
    end
    return k;
  endfunction

  function automatic rgp_gmii_t rx_encode(input rgp_rx_kind_t k, input logic [7:0] d);
    rgp_gmii_t g;
    g.en = 1'b0;
    g.er = 1'b1;
    g.data = d;
    unique case (k)
      RX_DATA: begin
        g.en = 1'b1;
        g.er = 1'b0;
      end
      RX_DATA_ERR: begin
        g.en = 1'b1;
      end
      RX_FALSE_CARR: begin
        g.data = RGP_CODE_FALSE_CARR;
      end
      RX_EXT: begin
        g.data = RGP_CODE_EXT;
      end
      RX_EXT_ERR: begin
        g.data = RGP_CODE_EXT_ERR;
      end
      RX_CARR_SENSE: begin
        g.data = RGP_CODE_CARR_SENSE;
      end
      default: begin
        g.er = 1'b0;
      end
    endcase
    return g;
  endfunction

  function automatic logic [7:0] half_sel(input logic [1:0] spd);
    logic [7:0] h;
    h = RGP_HALF_10;
    if (spd == RGP_SPD_1000) begin
      h = RGP_HALF_1000;
    end else if (spd == RGP_SPD_100) begin
      h = RGP_HALF_100;
    end
    return h;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rgp_pins_t sy1;
    rgp_pins_t sy2;
    logic prev_clk;
    logic have_rise;
    logic [3:0] lo_nib;
    logic rise_ctl;
    logic tx_valid;
    rgp_gmii_t tx;
    rgp_tx_kind_t tx_kind;
    rgp_pins_t rx;
    logic [7:0] cnt;
    logic [7:0] half;
    rgp_gmii_t cur;
  } rgp_state_t;

  localparam rgp_pins_t PINS_RST = '{clk: 1'b0, d: RGP_NIB_RST, ctl: 1'b0};
  localparam rgp_gmii_t GMII_RST = '{en: 1'b0, er: 1'b0, data: 8'h00};

  rgp_state_t s;
  rgp_state_t next_s;
  logic [3:0] status_nib;
  logic ready;

  assign status_nib = {full_duplex, speed, link_up};
  assign ready = (s.cnt == RGP_CNT_RST) && !s.rx.clk;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Pins from the MAC pass two flops; only the second stage is read.
    next_s.sy1 = tx_pins;
    next_s.sy2 = s.sy1;
    next_s.prev_clk = s.sy2.clk;
    next_s.tx_valid = 1'b0;
    if (s.sy2.clk && !s.prev_clk) begin
      next_s.lo_nib = s.sy2.d;
      next_s.rise_ctl = s.sy2.ctl;
      next_s.have_rise = 1'b1;
    end else if (!s.sy2.clk && s.prev_clk && s.have_rise) begin
      next_s.have_rise = 1'b0;
      next_s.tx_valid = 1'b1;
      next_s.tx.en = s.rise_ctl;
      next_s.tx.er = s.rise_ctl ^ s.sy2.ctl;
      next_s.tx.data = {s.sy2.d, s.lo_nib};
      next_s.tx_kind = tx_decode('{en: s.rise_ctl, er: s.rise_ctl ^ s.sy2.ctl,
                                   data: {s.sy2.d, s.lo_nib}});
    end
    // Receive clock divider; speed is taken only at a cycle start.
    if (s.cnt != RGP_CNT_RST) begin
      next_s.cnt = s.cnt - 8'h01;
    end else if (!s.rx.clk) begin
      next_s.half = half_sel(speed);
      next_s.cnt = half_sel(speed) - 8'h01;
      next_s.rx.clk = 1'b1;
      if (rx_valid) begin
        next_s.cur = rx_encode(rx_kind, rx_data);
      end else begin
        next_s.cur = '{en: 1'b0, er: 1'b0, data: {status_nib, status_nib}};
      end
      next_s.rx.d = next_s.cur.data[3:0];
      next_s.rx.ctl = next_s.cur.en;
    end else begin
      next_s.cnt = s.half - 8'h01;
      next_s.rx.clk = 1'b0;
      next_s.rx.d = s.cur.data[7:4];
      next_s.rx.ctl = s.cur.en ^ s.cur.er;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '{sy1: PINS_RST, sy2: PINS_RST, prev_clk: 1'b0, have_rise: 1'b0,
             lo_nib: RGP_NIB_RST, rise_ctl: 1'b0, tx_valid: 1'b0, tx: GMII_RST,
             tx_kind: TX_IDLE, rx: PINS_RST, cnt: RGP_CNT_RST, half: RGP_HALF_10,
             cur: GMII_RST};
    end else begin
      s <= next_s;
    end
  end

  assign rx_pins = s.rx;
  assign tx_valid = s.tx_valid;
  assign tx_byte = s.tx;
  assign tx_kind = s.tx_kind;
  assign rx_ready = ready;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic [7:0] run;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run <= RGP_CNT_RST;
    end else if (s.rx.clk != next_s.rx.clk) begin
      run <= RGP_CNT_RST;
    end else if (run != 8'hff) begin
      run <= run + 8'h01;
    end
  end

  sequence s_take;
    ready;
  endsequence

  sequence s_fall_with(logic lvl);
    ##[1:60] ($fell(rx_pins.clk) && (rx_pins.ctl == lvl));
  endsequence

  property p_ready_rises;
    s_take |=> $rose(rx_pins.clk);
  endproperty
  a_ready_rises: assert property (p_ready_rises) else $error("rxc did not rise");

  property p_rise_ctl;
    $rose(rx_pins.clk) |-> rx_pins.ctl == s.cur.en && rx_pins.d == s.cur.data[3:0];
  endproperty
  a_rise_ctl: assert property (p_rise_ctl) else $error("bad rising edge value");

  property p_fall_ctl;
    $fell(rx_pins.clk) |-> rx_pins.ctl == (s.cur.en ^ s.cur.er)
      && rx_pins.d == s.cur.data[7:4];
  endproperty
  a_fall_ctl: assert property (p_fall_ctl) else $error("bad falling edge value");

  property p_data_hh;
    s_take and rx_valid && rx_kind == RX_DATA |=> rx_pins.ctl ##0 s_fall_with(1'b1);
  endproperty
  a_data_hh: assert property (p_data_hh) else $error("good frame not high high");

  property p_idle_ll;
    s_take and !rx_valid |=> !rx_pins.ctl ##0 s_fall_with(1'b0);
  endproperty
  a_idle_ll: assert property (p_idle_ll) else $error("idle not low low");

  property p_err_hl;
    s_take and rx_valid && rx_kind == RX_DATA_ERR |=> rx_pins.ctl ##0 s_fall_with(1'b0);
  endproperty
  a_err_hl: assert property (p_err_hl) else $error("error frame not high low");

  property p_carr_sense;
    s_take and rx_valid && rx_kind == RX_CARR_SENSE |=> !rx_pins.ctl && rx_pins.d == 4'hf
      ##0 s_fall_with(1'b1) ##0 rx_pins.d == 4'hf;
  endproperty
  a_carr_sense: assert property (p_carr_sense) else $error("carrier sense code wrong");

  property p_tx_data_kind;
    tx_valid && tx_byte.en && !tx_byte.er |-> tx_kind == TX_DATA;
  endproperty
  a_tx_data_kind: assert property (p_tx_data_kind) else $error("data not decoded");

  property p_tx_pulse;
    tx_valid |=> !tx_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("byte pulse too long");

  property p_stretch;
    int'(run) < RGP_RUN_MAX;
  endproperty
  a_stretch: assert property (p_stretch) else $error("rxc level held too long");

  property p_half_len;
    $rose(rx_pins.clk) && s.half == RGP_HALF_100 |-> rx_pins.clk [*2];
  endproperty
  a_half_len: assert property (p_half_len) else $error("100M half period short");

endmodule

`default_nettype wire

// *** rgp_pkg.sv ***
// Constants, carrier types and the half-period helper function of the reduced-pin PHY end.
// Assumes a single 100 MHz core clock and a MAC that sends TXC slow enough to sample.
`default_nettype none

package rgp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int RGP_CLK_NS = 10;
  localparam int RGP_PER_1000_NS = 8;
  localparam int RGP_PER_100_NS = 40;
  localparam int RGP_PER_10_NS = 400;
  localparam int RGP_STRETCH_PERIODS = 3;

  // Half period in core cycles, rounded down and never below one cycle.
  function automatic logic [7:0] rgp_half(input int per_ns);
    int c;
    c = per_ns / (2 * RGP_CLK_NS);
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] RGP_HALF_1000 = rgp_half(RGP_PER_1000_NS);
  localparam logic [7:0] RGP_HALF_100 = rgp_half(RGP_PER_100_NS);
  localparam logic [7:0] RGP_HALF_10 = rgp_half(RGP_PER_10_NS);
  localparam int RGP_RUN_MAX = RGP_STRETCH_PERIODS * 2 * int'(RGP_HALF_10);

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] RGP_SPD_10 = 2'h0;
  localparam logic [1:0] RGP_SPD_100 = 2'h1;
  localparam logic [1:0] RGP_SPD_1000 = 2'h2;
  localparam logic [7:0] RGP_CODE_FALSE_CARR = 8'h0e;
  localparam logic [7:0] RGP_CODE_EXT = 8'h0f;
  localparam logic [7:0] RGP_CODE_EXT_ERR = 8'h1f;
  localparam logic [7:0] RGP_CODE_CARR_SENSE = 8'hff;
  localparam logic [7:0] RGP_CNT_RST = 8'h00;
  localparam logic [3:0] RGP_NIB_RST = 4'h0;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_ERR = 3'b010,
    TX_EXT = 3'b011,
    TX_EXT_ERR = 3'b100,
    TX_RSVD = 3'b101
  } rgp_tx_kind_t;

  typedef enum logic [2:0] {
    RX_DATA = 3'b000,
    RX_DATA_ERR = 3'b001,
    RX_FALSE_CARR = 3'b010,
    RX_EXT = 3'b011,
    RX_EXT_ERR = 3'b100,
    RX_CARR_SENSE = 3'b101
  } rgp_rx_kind_t;

  typedef struct packed {
    logic clk;
    logic [3:0] d;
    logic ctl;
  } rgp_pins_t;

  typedef struct packed {
    logic en;
    logic er;
    logic [7:0] data;
  } rgp_gmii_t;

endpackage

`default_nettype wire

// *** rgp_mac_model.sv ***
// Behavioural MAC end facing the PHY end of the reduced-pin link.
// Assumes a free-running mac_clk from the bench; TXC is mac_clk divided by ten.
`default_nettype none

module rgp_mac_model
  import rgp_pkg::*;
(
  // Own clock
  input wire logic mac_clk,
  // Link pins
  output var rgp_pins_t tx_pins,
  input wire rgp_pins_t rx_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  rgp_gmii_t rx_last = '0;
  logic [7:0] rx_cnt = 8'h00;
  logic [3:0] rx_lo = 4'h0;
  logic rx_dv = 1'b0;

  // ----------------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------------
  // TX_CTL stays low until the first byte is sent.
  initial tx_pins = '{clk: 1'b0, d: 4'h9, ctl: 1'b0};

  // TXC runs only while a byte is sent and stands still between sends.
  task automatic send(input logic en, input logic er, input logic [7:0] b);
    @(posedge mac_clk);
    tx_pins <= '{clk: 1'b1, d: b[3:0], ctl: en};
    repeat (5) @(posedge mac_clk);
    tx_pins <= '{clk: 1'b0, d: b[7:4], ctl: en ^ er};
    repeat (5) @(posedge mac_clk);
    // Hold time is over, so the data wires stop showing the byte.
    tx_pins.d <= ~b[7:4];
  endtask

  // ----------------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------------
  always @(posedge rx_pins.clk) begin
    rx_lo <= rx_pins.d;
    rx_dv <= rx_pins.ctl;
  end

  always @(negedge rx_pins.clk) begin
    rx_last <= '{en: rx_dv, er: rx_dv ^ rx_pins.ctl, data: {rx_pins.d, rx_lo}};
    rx_cnt <= rx_cnt + 8'h01;
  end

endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the PHY end of the reduced-pin link.
// Assumes rgp_pkg, rgp_phy and rgp_mac_model are compiled before it.
`default_nettype none

module tb
  import rgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic rst_n;
  logic mac_clk;
  rgp_pins_t tx_pins;
  rgp_pins_t rx_pins;
  logic tx_valid;
  rgp_gmii_t tx_byte;
  rgp_tx_kind_t tx_kind;
  logic rx_valid;
  rgp_rx_kind_t rx_kind;
  logic [7:0] rx_data;
  logic rx_ready;
  logic [1:0] speed;
  logic link_up;
  logic full_duplex;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_tx = 0;
  rgp_gmii_t got_b;
  rgp_tx_kind_t got_k;
  logic prev_rxc = 1'b0;
  logic [7:0] per_cnt = 8'h00;
  logic [7:0] since = 8'h00;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    mac_clk = 1'b0;
    forever #6.25 mac_clk = ~mac_clk;
  end

  rgp_phy rgp_phy_i (.clock(clock), .rst_n(rst_n), .tx_pins(tx_pins), .rx_pins(rx_pins),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_kind(tx_kind), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_data(rx_data), .rx_ready(rx_ready), .speed(speed),
    .link_up(link_up), .full_duplex(full_duplex));

  rgp_mac_model rgp_mac_model_i (.mac_clk(mac_clk), .tx_pins(tx_pins), .rx_pins(rx_pins));

  // ----------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev_rxc <= rx_pins.clk;
    since <= (rx_pins.clk && !prev_rxc) ? 8'h01 : since + 8'h01;
    if (rx_pins.clk && !prev_rxc) begin
      per_cnt <= since;
    end
    if (tx_valid === 1'b1) begin
      got_b <= tx_byte;
      got_k <= tx_kind;
      n_tx <= n_tx + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wait_rx();
    logic [7:0] c0;
    int i;
    c0 = rgp_mac_model_i.rx_cnt;
    for (i = 0; i < 100 && rgp_mac_model_i.rx_cnt == c0; i++) begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic tx_one(input logic en, input logic er, input logic [7:0] b,
                        input logic [2:0] k);
    int n0;
    int i;
    n0 = n_tx;
    rgp_mac_model_i.send(en, er, b);
    for (i = 0; i < 20 && n_tx == n0; i++) begin
      @(posedge clock);
    end
    chk("tx byte", {6'h00, en, er, b}, {6'h00, got_b});
    chk("tx kind", {13'h0000, k}, {13'h0000, got_k});
  endtask

  task automatic rx_one(input logic [2:0] k, input logic [7:0] d);
    logic [9:0] exp;
    int i;
    case (k)
      3'h0: exp = {2'b10, d};
      3'h1: exp = {2'b11, d};
      3'h2: exp = {2'b01, 8'h0e};
      3'h3: exp = {2'b01, 8'h0f};
      3'h4: exp = {2'b01, 8'h1f};
      default: exp = {2'b01, 8'hff};
    endcase
    rx_kind = rgp_rx_kind_t'(k);
    rx_data = d;
    rx_valid = 1'b1;
    for (i = 0; i < 100 && rx_ready !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    wait_rx();
    chk("rx byte", {6'h00, exp}, {6'h00, rgp_mac_model_i.rx_last});
  endtask

  task automatic test_tx_codes();
    tx_one(1'b0, 1'b0, 8'h3c, TX_IDLE);
    tx_one(1'b1, 1'b0, 8'ha5, TX_DATA);
    tx_one(1'b1, 1'b1, 8'h5a, TX_ERR);
    tx_one(1'b0, 1'b1, 8'h0f, TX_EXT);
    tx_one(1'b0, 1'b1, 8'h1f, TX_EXT_ERR);
    tx_one(1'b0, 1'b1, 8'h0e, TX_RSVD);
    tx_one(1'b0, 1'b1, 8'hff, TX_RSVD);
  endtask

  task automatic test_rx();
    logic [7:0] per_exp [3];
    per_exp[0] = 8'(RGP_PER_10_NS / RGP_CLK_NS);
    per_exp[1] = 8'(RGP_PER_100_NS / RGP_CLK_NS);
    // The gigabit half period rounds to one core cycle.
    per_exp[2] = 8'(2 * RGP_HALF_1000);
    for (int s = 2; s >= 0; s--) begin
      speed = s[1:0];
      for (int k = 0; k < 6; k++) begin
        rx_one(k[2:0], 8'h3c + 8'(k));
      end
      chk("rxc period", {8'h00, per_exp[s]}, {8'h00, per_cnt});
    end
  endtask

  task automatic test_idle();
    for (int j = 0; j < 2; j++) begin
      speed = j[0] ? RGP_SPD_100 : RGP_SPD_1000;
      link_up = ~j[0];
      full_duplex = j[0];
      repeat (3) wait_rx();
      chk("idle byte", {8'h00, {2{full_duplex, speed, link_up}}},
          {6'h00, rgp_mac_model_i.rx_last});
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rx_valid = 1'b0;
    rx_kind = RX_DATA;
    rx_data = 8'h00;
    speed = RGP_SPD_1000;
    link_up = 1'b1;
    full_duplex = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    chk("reset pins", 16'h0000, {10'h000, rx_pins});
    chk("reset valid", 16'h0000, {15'h0000, tx_valid});
    chk("reset ready", 16'h0001, {15'h0000, rx_ready});
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    test_tx_codes();
    test_rx();
    test_idle();
    wrap_up();
  end

endmodule

`default_nettype wire
